// ### svrw_cpu_model.sv
`default_nettype none

module svrw_cpu_model #(
	parameter int PER = 50
) (
	// Clock and reset state
	input  wire logic ref_clk,
	input  wire logic reset_out_n,
	// Test control
	input  wire logic hang,
	// Service line
	output var  logic watchdog_service_in
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	initial watchdog_service_in = 1'b0;
	// A running processor flips the line well inside each watchdog period.
	always @(posedge ref_clk) begin
		if (!reset_out_n || hang) begin
			cnt <= 0;
		end else if (cnt == PER - 1) begin
			cnt <= 0;
			watchdog_service_in <= ~watchdog_service_in;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

`default_nettype wire

// ### svrw_debounce.sv
`include "svrw_regs.svh"
`default_nettype none

// Filters the active-low manual reset input: the clean level changes only
// after the raw level has stood for the full settling count.
module svrw_debounce #(
	parameter int unsigned SETTLE = `SVRW_MRGLITCH_CYC
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	// Raw and filtered level
	input  wire logic raw_n,
	output var  logic clean_n
);

	logic [15:0] cnt_q;

	// ----------------------------------------------------------------------
	// Settling counter
	// ----------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cnt_q   <= 16'h0000;
			clean_n <= 1'b1;
		end else if (raw_n == clean_n) begin
			cnt_q <= 16'h0000;
		end else if (cnt_q >= 16'(SETTLE - 1)) begin
			cnt_q   <= 16'h0000;
			clean_n <= raw_n;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

endmodule

`default_nettype wire

// ### svrw_pkg.sv
`default_nettype none

package svrw_pkg;

	typedef enum logic [1:0] {
		SVRW_ST_ASSERT,
		SVRW_ST_HOLD,
		SVRW_ST_RUN
	} svrw_state_t;

endpackage

`default_nettype wire

// ### svrw_regs.svh
`ifndef SVRW_REGS_SVH
`define SVRW_REGS_SVH

// ----------------------------------------------------------------------
// Timing figures and derived cycle counts
// ----------------------------------------------------------------------
`define SVRW_CLK_PERIOD_NS   10
`define SVRW_HOLD_MS         140
`define SVRW_HOLD_CYC        ((`SVRW_HOLD_MS * 1000000) / `SVRW_CLK_PERIOD_NS)
`define SVRW_WDOG_MS         1600
`define SVRW_WDOG_CYC        ((`SVRW_WDOG_MS * 1000000) / `SVRW_CLK_PERIOD_NS)
`define SVRW_MRGLITCH_NS     1000
`define SVRW_MRGLITCH_CYC    ((`SVRW_MRGLITCH_NS + `SVRW_CLK_PERIOD_NS - 1) / `SVRW_CLK_PERIOD_NS)
`define SVRW_HOLD_RST        1'b1

`endif

// ### svrw_supervisor.sv
// Functional notes
// - Active-low reset output low on low supply, manual reset or expiry.
// - Active-high reset output high under the same three conditions.
// - After supply recovers, reset held for the hold period, then released.
// - Low manual reset input forces reset; outside party may pull it low.
// - Reset held while manual input low, plus hold period after release.
// - Service input steady beyond watchdog period expires, full hold reset.
// - Watchdog cleared by reset, manual reset, and any service edge.
// - Watchdog disable input suppresses expiry when service input floats.
// - Manual reset input debounced inside the block.
// - Watchdog period is 1.6 s; processor toggles within each period.
// - Watchdog stays cleared during reset, counts from reset release.
// - Service edge detector catches short pulses and clears the watchdog.
`include "svrw_regs.svh"
`default_nettype none

module svrw_supervisor #(
	parameter int unsigned HOLD_CYC  = `SVRW_HOLD_CYC,
	parameter int unsigned WDOG_CYC  = `SVRW_WDOG_CYC,
	parameter int unsigned MR_CYC    = `SVRW_MRGLITCH_CYC,
	parameter bit          OPEN_DRN  = 1'b0
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	// Monitored conditions
	input  wire logic supply_low,
	input  wire logic manual_reset_n,
	input  wire logic watchdog_service_in,
	input  wire logic watchdog_disable,
	// Reset outputs
	output var  logic reset_out_n,
	output var  logic reset_out_n_oe,
	output var  logic reset_out
);

	logic                 mr_clean_n;
	logic                 wdi_q;
	logic                 wdi_edge;
	logic [27:0]          hold_q;
	logic [28:0]          wdog_q;
	logic                 expire;
	logic                 force_rst;
	svrw_pkg::svrw_state_t st_q;

	// ----------------------------------------------------------------------
	// Manual reset filter
	// ----------------------------------------------------------------------
	svrw_debounce #(
		.SETTLE (MR_CYC)
	) u_mr_filter (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.raw_n   (manual_reset_n),
		.clean_n (mr_clean_n)
	);

	// ----------------------------------------------------------------------
	// Service input edge detection
	// ----------------------------------------------------------------------
	// A 10 ns sample catches any pulse of 10 ns or more.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			// Tracking the pin during reset avoids a false edge on release.
			wdi_q <= watchdog_service_in;
		end else begin
			wdi_q <= watchdog_service_in;
		end
	end

	assign wdi_edge = wdi_q ^ watchdog_service_in;

	// ----------------------------------------------------------------------
	// Watchdog timer
	// ----------------------------------------------------------------------
	assign expire = (wdog_q >= 29'(WDOG_CYC - 1)) && !watchdog_disable
		&& !wdi_edge;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wdog_q <= 29'h0000000;
		end else if (st_q != svrw_pkg::SVRW_ST_RUN || !mr_clean_n
			|| wdi_edge || watchdog_disable || expire) begin
			wdog_q <= 29'h0000000;
		end else begin
			wdog_q <= wdog_q + 29'h0000001;
		end
	end

	// ----------------------------------------------------------------------
	// Reset sequencing
	// ----------------------------------------------------------------------
	assign force_rst = supply_low || !mr_clean_n;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_q   <= svrw_pkg::SVRW_ST_ASSERT;
			hold_q <= 28'h0000000;
		end else begin
			case (st_q)
				svrw_pkg::SVRW_ST_ASSERT: begin
					hold_q <= 28'h0000000;
					if (!force_rst) begin
						st_q <= svrw_pkg::SVRW_ST_HOLD;
					end
				end
				svrw_pkg::SVRW_ST_HOLD: begin
					if (force_rst) begin
						st_q   <= svrw_pkg::SVRW_ST_ASSERT;
						hold_q <= 28'h0000000;
					end else if (hold_q >= 28'(HOLD_CYC - 1)) begin
						st_q   <= svrw_pkg::SVRW_ST_RUN;
						hold_q <= 28'h0000000;
					end else begin
						hold_q <= hold_q + 28'h0000001;
					end
				end
				svrw_pkg::SVRW_ST_RUN: begin
					hold_q <= 28'h0000000;
					if (force_rst) begin
						st_q <= svrw_pkg::SVRW_ST_ASSERT;
					end else if (expire) begin
						st_q <= svrw_pkg::SVRW_ST_HOLD;
					end
				end
				default: begin
					st_q   <= svrw_pkg::SVRW_ST_ASSERT;
					hold_q <= 28'h0000000;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------------
	// Output stage
	// ----------------------------------------------------------------------
	// Both pins load from one next-state term so they switch together.
	logic rst_d;

	always_comb begin
		rst_d = 1'b1;
		case (st_q)
			svrw_pkg::SVRW_ST_ASSERT: rst_d = 1'b1;
			svrw_pkg::SVRW_ST_HOLD:   rst_d = 1'b1;
			svrw_pkg::SVRW_ST_RUN:    rst_d = force_rst || expire;
			default:                  rst_d = 1'b1;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			reset_out_n    <= !`SVRW_HOLD_RST;
			reset_out      <= `SVRW_HOLD_RST;
			reset_out_n_oe <= 1'b1;
		end else begin
			reset_out_n    <= !rst_d;
			reset_out      <= rst_d;
			reset_out_n_oe <= OPEN_DRN ? rst_d : 1'b1;
		end
	end

	// ----------------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------------
	outputs_complement_a: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		reset_out == !reset_out_n)
		else $error("reset outputs not complementary");

	supply_asserts_a: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		supply_low |=> reset_out)
		else $error("low supply did not assert reset");

	manual_asserts_a: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		!mr_clean_n |=> !reset_out_n)
		else $error("manual reset did not assert reset");

	sequence quiet_run_s;
		st_q == svrw_pkg::SVRW_ST_RUN && !force_rst && !expire;
	endsequence

	hold_release_a: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		$fell(reset_out) |-> $past(hold_q, 2) == 28'(HOLD_CYC - 1))
		else $error("reset released before hold period");

	expiry_hold_a: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		expire && !force_rst |=> st_q == svrw_pkg::SVRW_ST_HOLD
		##1 reset_out)
		else $error("expiry did not start hold");

	wdog_cleared_a: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		st_q != svrw_pkg::SVRW_ST_RUN |=> wdog_q == 29'h0000000)
		else $error("watchdog counted during reset");

	edge_clears_a: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		wdi_edge |=> wdog_q == 29'h0000000)
		else $error("service edge did not clear watchdog");

	disable_blocks_a: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		watchdog_disable && !force_rst && !reset_out |=> !reset_out)
		else $error("watchdog expired while disabled");

	glitch_reject_a: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		manual_reset_n && $past(manual_reset_n) |=> mr_clean_n
		|| $past(mr_clean_n) == 1'b0)
		else $error("manual filter fell without a low input");

	run_stays_a: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		quiet_run_s |=> !reset_out)
		else $error("run state inconsistent");

endmodule

`default_nettype wire

// ### tb.sv
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HOLD = 50;
	localparam int WDOG = 200;
	localparam int MRC = 4;
	typedef struct {int sup; int man; bit exp;} svrw_row_t;
	svrw_row_t rows[4] = '{'{3, 0, 1}, '{0, 2, 0}, '{0, 10, 1}, '{1, 0, 1}};
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic supply_low = 1'b0;
	logic manual_reset_n = 1'b1;
	logic watchdog_disable = 1'b0;
	logic hang = 1'b0;
	logic wsi, rst_n, rst_n_oe, rst, seen;
	logic od_rst_n, od_oe;
	int errors = 0;
	int checks_done = 0;
	int cycles = 0;
	int n;
	svrw_supervisor #(.HOLD_CYC(HOLD), .WDOG_CYC(WDOG), .MR_CYC(MRC),
		.OPEN_DRN(1'b0)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.supply_low(supply_low), .manual_reset_n(manual_reset_n),
		.watchdog_service_in(wsi), .watchdog_disable(watchdog_disable),
		.reset_out_n(rst_n), .reset_out_n_oe(rst_n_oe), .reset_out(rst));
	svrw_supervisor #(.HOLD_CYC(HOLD), .WDOG_CYC(WDOG), .MR_CYC(MRC),
		.OPEN_DRN(1'b1)) i_dut_od (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.supply_low(supply_low), .manual_reset_n(manual_reset_n),
		.watchdog_service_in(wsi), .watchdog_disable(watchdog_disable),
		.reset_out_n(od_rst_n), .reset_out_n_oe(od_oe), .reset_out());
	svrw_cpu_model #(.PER(50)) i_cpu (.ref_clk(ref_clk),
		.reset_out_n(rst_n), .hang(hang), .watchdog_service_in(wsi));
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			errors++;
			give_verdict();
		end
	end
	always @(negedge ref_clk) begin
		chk1(rst ^ rst_n, 1'b1);
		chk1(rst_n_oe, 1'b1);
		chk1(od_oe ^ od_rst_n, 1'b1);
	end
	// ----------------
	// Helpers
	// ----------------
	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	task automatic chk1(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_rng(input int got, input int lo, input int hi);
		checks_done++;
		if (got < lo || got > hi) begin
			errors++;
			$display("BAD t=%0t got=%h lo=%h hi=%h", $time, got, lo, hi);
		end
	endtask
	task automatic watch(input int k);
		seen = 1'b0;
		repeat (k) begin
			tick(1);
			seen |= rst;
		end
	endtask
	task automatic wait_lvl(input logic lvl, output int c);
		c = 0;
		while (rst !== lvl && c < 2000) begin
			tick(1);
			c++;
		end
	endtask
	task automatic give_verdict();
		$display("checks=%0d errors=%0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ----------------
	// Tests
	// ----------------
	initial begin
		tick(20);
		sys_rst = 1'b0;
		tick(1);
		chk1(rst, 1'b1);
		wait_lvl(1'b0, n);
		chk_rng(n, HOLD - 1, HOLD + 6);
		$display("test reset done");
		foreach (rows[i]) begin
			seen = 1'b0;
			for (int k = 0; k < rows[i].sup + rows[i].man + 3; k++) begin
				supply_low = k < rows[i].sup;
				manual_reset_n = !(k < rows[i].man);
				tick(1);
				seen |= rst;
			end
			chk1(seen, rows[i].exp);
			if (rows[i].exp) begin
				wait_lvl(1'b0, n);
				chk_rng(n + 3, HOLD, HOLD + MRC + 6);
			end
			$display("test row %0d done", i);
		end
		hang = 1'b1;
		wait_lvl(1'b1, n);
		chk_rng(n, WDOG - 50, WDOG + 5);
		wait_lvl(1'b0, n);
		chk_rng(n, HOLD - 1, HOLD + 6);
		wait_lvl(1'b1, n);
		chk_rng(n, WDOG - 1, WDOG + 5);
		hang = 1'b0;
		wait_lvl(1'b0, n);
		watch(3 * WDOG);
		chk1(seen, 1'b0);
		$display("test watchdog done");
		watchdog_disable = 1'b1;
		hang = 1'b1;
		watch(2 * WDOG);
		chk1(seen, 1'b0);
		$display("test disable done");
		sys_rst = 1'b1;
		tick(3);
		chk1(rst, 1'b1);
		sys_rst = 1'b0;
		wait_lvl(1'b0, n);
		chk_rng(n, HOLD - 1, HOLD + 6);
		$display("test mid-run reset done");
		give_verdict();
	end
endmodule

`default_nettype wire
